// [include/lcs_pkg.sv]
// constants and types for the command sequencer with row repair
package lcs_pkg;

   // clock and timing (times in ns, counts derived from the 5 ns clock)
   localparam int CLK_PERIOD_NS = 5;
   localparam int FUSE_PROGRAM_TIME_NS = 2000;
   localparam int FIX_EXIT_TIME_NS = 100;
   localparam int POST_FIX_SETTLE_TIME_NS = 500;
   // least times round up to whole cycles
   localparam int FUSE_PROGRAM_CYC = (FUSE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIX_EXIT_CYC = (FIX_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POST_FIX_SETTLE_CYC = (POST_FIX_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // field positions, mode register addresses and the deselect count after MPC
   localparam int FIX_ENABLE_BIT = 4;
   localparam logic [5:0] FIX_ENABLE_MODE_REGISTER = 6'h04;
   localparam logic [5:0] FIX_RESOURCE_MODE_REGISTER = 6'h19;
   localparam int MPC_NEEDS_CAS2_BIT = 6;
   localparam int DES_AFTER_MPC = 2;

   // reset value and all-bank select
   localparam logic [7:0] MR_FIX_ENABLE_RESET = 8'h00;
   localparam logic [7:0] BANK_ALL = 8'hFF;

   // first-cycle command kinds
   typedef enum logic [3:0] {
      K_MPC = 4'h0, K_PRE = 4'h1, K_REF = 4'h2, K_SRE = 4'h3,
      K_WR1 = 4'h4, K_SRX = 4'h5, K_MWR1 = 4'h6, K_RD1 = 4'h7,
      K_CAS2 = 4'h8, K_MRW1 = 4'h9, K_MRW2 = 4'hA, K_MRR1 = 4'hB,
      K_ACT1 = 4'hC, K_ACT2 = 4'hD, K_RFU = 4'hE
   } lcs_kind_t;

   // command bus phase
   typedef enum logic [0:0] {
      PH_FIRST = 1'b0,
      PH_SECOND = 1'b1
   } lcs_phase_t;

   // which second half the previous first half demands
   typedef enum logic [1:0] {
      NEED_NONE = 2'b00,
      NEED_CAS2 = 2'b01,
      NEED_ACT2 = 2'b10,
      NEED_MRW2 = 2'b11
   } lcs_need_t;

endpackage

// [logic/lcs_sequencer.sv]
// command-bus decoder, pairing monitor and fail-row repair engine
// Function
// - non-deselect commands span two cycles, deselect one
// - bank commands go to second-cycle bank field
// - all-bank flag acts on every bank
// - auto-precharge flag closes bank after access
// - on-the-fly burst flag picks 32 or 16
// - low column bits zero; masked write bits 3:2 low
// - repair availability readable from its mode register
// - at most one repaired row per bank
// - after settle time, any valid command accepted
module lcs_sequencer
   import lcs_pkg::*;
#(
   parameter logic [7:0] FIX_RESOURCE = 8'h01, // repair available
   parameter int PROG_CYC = FUSE_PROGRAM_CYC,
   parameter int EXIT_CYC = FIX_EXIT_CYC,
   parameter int SETTLE_CYC = POST_FIX_SETTLE_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // command pins
   input wire logic cs,
   input wire logic [5:0] ca,
   // configuration
   input wire logic otf_enable, // burst length chosen per command
   input wire logic fixed_bl32, // burst when on-the-fly is off
   // decoded command
   output logic cmd_valid,
   output logic [3:0] cmd_kind,
   output logic [7:0] bank_sel,
   output logic auto_pre,
   output logic burst32,
   output logic [9:0] col,
   output logic [15:0] row,
   // mode register traffic
   output logic mrr_valid,
   output logic [7:0] mrr_data,
   // repair status
   output logic fix_mode,
   output logic fix_busy,
   output logic [7:0] fix_used,
   output logic [15:0] fixed_row,
   output logic protocol_error
);

   ////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic cs_m; // first sync stage
      logic [5:0] ca_m;
      logic cs_s; // second sync stage
      logic [5:0] ca_s;
      lcs_phase_t phase;
      lcs_kind_t kind; // kind taken at first edge
      logic ca5_r1; // CA5 of the first cycle
      logic [2:0] ca_r1_low; // CA4:2 of the first cycle, middle row bits
      lcs_need_t need; // pending second half
      logic [1:0] des_left; // deselects still owed
      logic [2:0] p_bank; // bank of pending column or activate command
      logic p_ap;
      logic p_bl32;
      logic p_c9;
      logic p_mrr; // pending column pair is a mode read
      logic p_wr; // pending column pair is a write, bits 3:2 must be low
      logic [5:0] p_ma;
      logic p_op7;
      logic [5:0] row_hi;
      logic [7:0] mr4;
      logic armed; // failing row latched, programming
      logic [15:0] prog_cnt;
      logic [2:0] fix_bank;
      logic [15:0] fix_row;
      logic exiting; // fuse blown, exit time running
      logic [15:0] exit_cnt;
      logic [15:0] settle_cnt;
      logic cmd_valid;
      logic [3:0] cmd_kind;
      logic [7:0] bank_sel;
      logic auto_pre;
      logic burst32;
      logic [9:0] col;
      logic [15:0] row;
      logic mrr_valid;
      logic [7:0] mrr_data;
      logic fix_busy;
      logic [7:0] fix_used;
      logic [15:0] fixed_row;
      logic protocol_error;
   } lcs_state_t;

   lcs_state_t st;
   lcs_state_t next_st;

   ////////////////////////////////////////////////////////////////////
   // first-cycle kind from CA[4:0]
   function automatic lcs_kind_t decode_kind(input logic [4:0] c);
      lcs_kind_t k;
      k = K_RFU;
      if (c[0]) begin
         k = c[1] ? K_ACT2 : K_ACT1;
      end else begin
         case (c[4:1])
            4'h0: k = K_MPC;
            4'h8: k = K_PRE;
            4'h4: k = K_REF;
            4'hC: k = K_SRE;
            4'h2: k = K_WR1;
            4'hA: k = K_SRX;
            4'h6: k = K_MWR1;
            4'h1: k = K_RD1;
            4'h9: k = K_CAS2;
            4'h3: k = K_MRW1;
            4'hB: k = K_MRW2;
            4'h7: k = K_MRR1;
            default: k = K_RFU;
         endcase
      end
      return k;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      lcs_kind_t k;
      logic [2:0] ba;
      logic fixing;
      k = decode_kind(st.ca_s[4:0]);
      ba = st.ca_s[2:0];
      fixing = st.mr4[FIX_ENABLE_BIT];
      next_st = st;
      // pins pass two flops before anything reads them
      next_st.cs_m = cs;
      next_st.ca_m = ca;
      next_st.cs_s = st.cs_m;
      next_st.ca_s = st.ca_m;
      // pulses default low
      next_st.cmd_valid = 1'b0;
      next_st.mrr_valid = 1'b0;
      // repair timers
      if (st.armed && st.prog_cnt != 16'hFFFF) begin
         next_st.prog_cnt = st.prog_cnt + 16'h0001;
      end
      if (st.exiting && st.exit_cnt != 16'hFFFF) begin
         next_st.exit_cnt = st.exit_cnt + 16'h0001;
      end
      if (st.fix_busy) begin
         // device takes commands again once settle time has run out
         if (st.settle_cnt >= 16'(SETTLE_CYC - 1)) begin
            next_st.fix_busy = 1'b0;
         end
         next_st.settle_cnt = st.settle_cnt + 16'h0001;
      end

      if (st.phase == PH_FIRST) begin
         // deselect: cs low, one cycle only
         if (st.cs_s) begin
            next_st.phase = PH_SECOND;
            next_st.kind = k;
            next_st.ca5_r1 = st.ca_s[5];
            next_st.ca_r1_low = st.ca_s[4:2];
            // oscillator/calibration spacing
            if (st.des_left != 2'b00) begin
               next_st.protocol_error = 1'b1;
            end
            // any command while repair settles is illegal
            if (st.fix_busy) begin
               next_st.protocol_error = 1'b1;
            end
            // second halves must match the pending first half
            case (st.need)
               NEED_CAS2: if (k != K_CAS2) next_st.protocol_error = 1'b1;
               NEED_ACT2: if (k != K_ACT2) next_st.protocol_error = 1'b1;
               NEED_MRW2: if (k != K_MRW2) next_st.protocol_error = 1'b1;
               default: begin
                  // orphan second halves and reserved codes
                  if (k == K_CAS2 || k == K_ACT2 || k == K_MRW2 || k == K_RFU) begin
                     next_st.protocol_error = 1'b1;
                  end
               end
            endcase
            // masked write carries CA5 low
            if (k == K_MWR1 && st.ca_s[5]) begin
               next_st.protocol_error = 1'b1;
            end
         end else if (st.des_left != 2'b00) begin
            next_st.des_left = st.des_left - 2'b01;
         end
      end else begin
         // second cycle: cs must be low
         next_st.phase = PH_FIRST;
         next_st.need = NEED_NONE;
         if (st.cs_s) begin
            next_st.protocol_error = 1'b1;
         end
         next_st.cmd_kind = st.kind;
         next_st.bank_sel = 8'h01 << ba;
         next_st.auto_pre = 1'b0;
         case (st.kind)
            K_MPC: begin
               if (st.ca5_r1) begin
                  // fifo and calibration reads pair with CAS-2
                  next_st.need = NEED_CAS2;
                  next_st.p_mrr = 1'b0;
                  next_st.p_wr = 1'b0;
               end else begin
                  next_st.des_left = 2'(DES_AFTER_MPC);
                  next_st.cmd_valid = 1'b1;
               end
            end
            K_PRE, K_REF: begin
               next_st.cmd_valid = 1'b1;
               // all-bank flag overrides the bank field
               if (st.ca5_r1) begin
                  next_st.bank_sel = BANK_ALL;
               end
               // precharge ending a repair commits the fuse
               if (st.kind == K_PRE && fixing && st.armed) begin
                  next_st.armed = 1'b0;
                  if (st.prog_cnt < 16'(PROG_CYC) || st.fix_used[st.fix_bank]) begin
                     next_st.protocol_error = 1'b1;
                  end else begin
                     next_st.fix_used[st.fix_bank] = 1'b1;
                     next_st.fixed_row = st.fix_row;
                     next_st.exiting = 1'b1;
                     next_st.exit_cnt = 16'h0000;
                  end
               end
            end
            K_WR1, K_MWR1, K_RD1: begin
               next_st.need = NEED_CAS2;
               next_st.p_mrr = 1'b0;
               next_st.p_bank = ba;
               next_st.p_c9 = st.ca_s[4];
               next_st.p_wr = (st.kind != K_RD1);
               next_st.p_ap = st.ca_s[5];
               // masked write is always burst 16
               if (st.kind == K_MWR1) begin
                  next_st.p_bl32 = 1'b0;
               end else begin
                  next_st.p_bl32 = otf_enable ? st.ca5_r1 : fixed_bl32;
               end
            end
            K_MRR1: begin
               next_st.need = NEED_CAS2;
               next_st.p_mrr = 1'b1;
               next_st.p_ma = st.ca_s;
            end
            K_CAS2: begin
               next_st.cmd_valid = 1'b1;
               next_st.bank_sel = 8'h01 << st.p_bank;
               next_st.auto_pre = st.p_ap;
               next_st.burst32 = st.p_bl32;
               // low two column bits never sent, read as zero
               next_st.col = {st.p_c9, st.ca5_r1, st.ca_s, 2'b00};
               // write halves must also send bits 3:2 low
               if ((st.need == NEED_CAS2) && !st.p_mrr && st.p_wr && st.ca_s[1:0] != 2'b00) begin
                  next_st.protocol_error = 1'b1;
               end
               if (st.p_mrr) begin
                  next_st.mrr_valid = 1'b1;
                  // repair resource report
                  if (st.p_ma == FIX_RESOURCE_MODE_REGISTER) begin
                     next_st.mrr_data = FIX_RESOURCE;
                  end else if (st.p_ma == FIX_ENABLE_MODE_REGISTER) begin
                     next_st.mrr_data = st.mr4;
                  end else begin
                     next_st.mrr_data = 8'h00;
                  end
               end
            end
            K_MRW1: begin
               next_st.need = NEED_MRW2;
               next_st.p_ma = st.ca_s;
               next_st.p_op7 = st.ca5_r1;
            end
            K_MRW2: begin
               next_st.cmd_valid = 1'b1;
               if (st.p_ma == FIX_ENABLE_MODE_REGISTER) begin
                  next_st.mr4 = {st.p_op7, st.ca5_r1, st.ca_s};
                  // leaving repair before the exit time is illegal
                  if (fixing && !st.ca_s[FIX_ENABLE_BIT]) begin
                     if (st.armed || (st.exiting && st.exit_cnt < 16'(EXIT_CYC))) begin
                        next_st.protocol_error = 1'b1;
                     end
                     next_st.exiting = 1'b0;
                     next_st.armed = 1'b0;
                     next_st.fix_busy = 1'b1;
                     next_st.settle_cnt = 16'h0000;
                  end
               end
            end
            K_ACT1: begin
               next_st.need = NEED_ACT2;
               next_st.p_bank = ba;
               // row 15:12 from the first cycle, 11:10 from the second
               next_st.row_hi = {st.ca5_r1, st.ca_r1_low, st.ca_s[5:4]};
            end
            K_ACT2: begin
               next_st.cmd_valid = 1'b1;
               next_st.bank_sel = 8'h01 << st.p_bank;
               next_st.row = {st.row_hi, st.ca5_r1, st.ca_r1_low, st.ca_s};
               // activate in repair mode names the failing row
               if (fixing) begin
                  next_st.armed = 1'b1;
                  next_st.prog_cnt = 16'h0000;
                  next_st.fix_bank = st.p_bank;
                  next_st.fix_row = {st.row_hi, st.ca5_r1, st.ca_r1_low, st.ca_s};
               end
            end
            default: begin
               next_st.cmd_valid = (st.kind != K_RFU);
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register; error sticks until reset reinitialises the part
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
         st.mr4 <= MR_FIX_ENABLE_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs straight from the state flops
   assign cmd_valid = st.cmd_valid;
   assign cmd_kind = st.cmd_kind;
   assign bank_sel = st.bank_sel;
   assign auto_pre = st.auto_pre;
   assign burst32 = st.burst32;
   assign col = st.col;
   assign row = st.row;
   assign mrr_valid = st.mrr_valid;
   assign mrr_data = st.mrr_data;
   assign fix_mode = st.mr4[FIX_ENABLE_BIT];
   assign fix_busy = st.fix_busy;
   assign fix_used = st.fix_used;
   assign fixed_row = st.fixed_row;
   assign protocol_error = st.protocol_error;

endmodule // lcs_sequencer

// [verif/lcs_sequencer_checker.sv]
// port-level assertions for the command sequencer
module lcs_sequencer_checker
   import lcs_pkg::*;
#(
   parameter int SETTLE_CYC = POST_FIX_SETTLE_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // pins and configuration
   input wire logic cs,
   input wire logic [5:0] ca,
   input wire logic otf_enable,
   input wire logic fixed_bl32,
   // decoded command
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_kind,
   input wire logic [7:0] bank_sel,
   input wire logic auto_pre,
   input wire logic burst32,
   input wire logic [9:0] col,
   input wire logic [15:0] row,
   // mode register and repair status
   input wire logic mrr_valid,
   input wire logic [7:0] mrr_data,
   input wire logic fix_mode,
   input wire logic fix_busy,
   input wire logic [7:0] fix_used,
   input wire logic [15:0] fixed_row,
   input wire logic protocol_error
);
   // margin covers the input synchroniser
   localparam int BUSY_MAX = SETTLE_CYC + 4;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // pin-side copy of the input stage; the result of a CAS-2 only names the second half,
   // so the burst checks need to know which first half it closed
   logic [1:0] cs_d; // cs one and two samples back
   logic [5:0] ca_m; // ca one sample back
   logic [5:0] ca_s; // ca two samples back
   logic ph; // next sample is a second cycle
   logic [1:0] col_k; // last first half: 2 masked write, 1 write or read, 0 other
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_d <= 2'h0;
         ca_m <= 6'h00;
         ca_s <= 6'h00;
         ph <= 1'h0;
         col_k <= 2'h0;
      end else begin
         cs_d <= {cs_d[0], cs};
         ca_m <= ca;
         ca_s <= ca_m;
         ph <= !ph && cs_d[1];
         // any first half but CAS-2 replaces the record
         if (!ph && cs_d[1] && ca_s[4:0] != 5'h12) begin
            col_k <= {(ca_s[4:0] == 5'h0C), (ca_s[4:0] == 5'h04 || ca_s[4:0] == 5'h02)};
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   valid_one_cycle_a: assert property (cmd_valid |=> !cmd_valid)
      else $error("command valid longer than one cycle");
   mrr_one_cycle_a: assert property (mrr_valid |=> !mrr_valid)
      else $error("read valid longer than one cycle");
   bank_select_a: assert property (cmd_valid && (cmd_kind == K_PRE || cmd_kind == K_REF)
      |-> ($onehot(bank_sel) || bank_sel == BANK_ALL)) else $error("bank select not one-hot");
   col_low_zero_a: assert property (cmd_valid |-> col[1:0] == 2'h0)
      else $error("low column bits not zero");
   masked_short_a: assert property (cmd_valid && cmd_kind == K_CAS2 && col_k == 2'h2 |-> !burst32)
      else $error("masked write not burst 16");
   fixed_burst_a: assert property (cmd_valid && !otf_enable && $stable(fixed_bl32)
      && cmd_kind == K_CAS2 && col_k == 2'h1 |-> burst32 == fixed_bl32) else $error("fixed burst wrong");
   fuse_once_a: assert property (fix_used != $past(fix_used) |-> $onehot(fix_used ^ $past(fix_used))
      && ($past(fix_used) & ~fix_used) == 8'h00 && (fix_mode || $past(fix_mode))) else $error("fuse change bad");
   busy_not_mode_a: assert property (fix_busy |-> !fix_mode)
      else $error("settle busy while in repair mode");
   busy_bounded_a: assert property ($rose(fix_busy) |-> ##[1:BUSY_MAX] !fix_busy)
      else $error("settle busy too long");
   error_sticky_a: assert property (protocol_error |=> protocol_error)
      else $error("protocol error cleared");
endmodule // lcs_sequencer_checker

bind lcs_sequencer lcs_sequencer_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk(clk), .nrst(nrst), .cs(cs),
   .ca(ca), .otf_enable(otf_enable), .fixed_bl32(fixed_bl32), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
   .bank_sel(bank_sel), .auto_pre(auto_pre), .burst32(burst32), .col(col), .row(row), .mrr_valid(mrr_valid),
   .mrr_data(mrr_data), .fix_mode(fix_mode), .fix_busy(fix_busy), .fix_used(fix_used), .fixed_row(fixed_row),
   .protocol_error(protocol_error));

// [verif/lcs_host_model.sv]
// host controller model driving the command bus
module lcs_host_model
   import lcs_pkg::*;
#(
   parameter int PROG_CYC = 4,
   parameter int EXIT_CYC = 2,
   parameter int SETTLE_CYC = 4,
   parameter int MODE_SET_DELAY = 4
) (
   // clock
   input wire logic clk,
   // command pins
   output logic cs,
   output logic [5:0] ca
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SYNC = 4; // slack for the input synchroniser
   logic busy; // a command owns the bus
   initial begin
      busy = 1'h0;
      cs = 1'h0;
      ca = 6'h00;
   end
   ////////////////////////////////////////////////////////////////
   // deselected bus wanders so stale values are never trusted
   always @(posedge clk) begin
      if (!busy && !cs) begin
         ca <= ~ca;
      end
   end
   // one command, or a first half with its second half right behind
   task automatic issue(input logic [5:0] a1, a2, b1, b2, input logic two);
      busy = 1'h1;
      @(posedge clk);
      cs <= 1'h1;
      ca <= a1;
      @(posedge clk);
      cs <= 1'h0;
      ca <= a2;
      if (two) begin
         @(posedge clk);
         cs <= 1'h1;
         ca <= b1;
         @(posedge clk);
         cs <= 1'h0;
         ca <= b2;
      end
      repeat (2) @(posedge clk);
      busy = 1'h0;
   endtask
   task automatic one(input logic [5:0] a1, a2);
      issue(a1, a2, 6'h00, 6'h00, 1'h0);
   endtask
   task automatic mrw(input logic [5:0] ma, input logic [7:0] op);
      issue({op[7], 5'h06}, ma, {op[6], 5'h16}, op[5:0], 1'h1);
   endtask
   task automatic mrr(input logic [5:0] ma);
      issue(6'h0E, ma, 6'h12, 6'h00, 1'h1);
   endtask
   task automatic act(input logic [2:0] ba, input logic [15:0] r);
      issue({r[15:12], 2'h1}, {r[11:10], 1'h0, ba}, {r[9:6], 2'h3}, r[5:0], 1'h1);
   endtask
   // column access: caller keeps bits 3:2 low for writes
   task automatic rw(input logic [4:0] code, input logic [2:0] ba, input logic bl, ap, input logic [9:0] c);
      issue({bl, code}, {ap, c[9], 1'h0, ba}, {c[8], 5'h12}, c[7:2], 1'h1);
   endtask
   // fuses are one-shot, so this runs only when called on purpose
   task automatic repair(input logic [2:0] ba, input logic [15:0] r);
      one(6'h30, 6'h00);
      repeat (MODE_SET_DELAY) @(posedge clk);
      mrw(FIX_ENABLE_MODE_REGISTER, 8'h10);
      repeat (MODE_SET_DELAY + SYNC) @(posedge clk);
      act(ba, r);
      repeat (PROG_CYC + SYNC) @(posedge clk);
      one(6'h10, {3'h0, ba});
      repeat (EXIT_CYC + SYNC) @(posedge clk);
      mrw(FIX_ENABLE_MODE_REGISTER, 8'h00);
      repeat (SETTLE_CYC + SYNC) @(posedge clk);
   endtask
endmodule // lcs_host_model

// [verif/tb_lcs_sequencer.sv]
// self-checking bench for the command sequencer
module tb_lcs_sequencer
   import lcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] RES = 8'h01; // repair available
   // short repair times keep the run brief; the host model defaults match them
   localparam int T_PROG = 4;
   localparam int T_EXIT = 2;
   localparam int T_SETTLE = 4;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic otf_enable = 1'h0;
   logic fixed_bl32 = 1'h0;
   logic cs, cmd_valid, mrr_valid, auto_pre, burst32, fix_mode, fix_busy, protocol_error;
   logic [5:0] ca;
   logic [3:0] cmd_kind;
   logic [7:0] bank_sel, mrr_data, fix_used;
   logic [9:0] col;
   logic [15:0] row, fixed_row;
   int n_errors = 0;
   int checks = 0;
   // bank command table: first cycle, bank, expected select
   logic [5:0] t_cmd[4] = '{6'h10, 6'h30, 6'h28, 6'h08};
   logic [2:0] t_ba[4] = '{3'h6, 3'h5, 3'h5, 3'h1};
   logic [7:0] t_sel[4] = '{8'h40, 8'hFF, 8'hFF, 8'h02};
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   lcs_sequencer #(.FIX_RESOURCE(RES), .PROG_CYC(T_PROG), .EXIT_CYC(T_EXIT), .SETTLE_CYC(T_SETTLE)) u_dut (.clk(clk),
      .nrst(nrst), .cs(cs), .ca(ca), .otf_enable(otf_enable), .fixed_bl32(fixed_bl32), .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind), .bank_sel(bank_sel), .auto_pre(auto_pre), .burst32(burst32), .col(col), .row(row),
      .mrr_valid(mrr_valid), .mrr_data(mrr_data), .fix_mode(fix_mode), .fix_busy(fix_busy),
      .fix_used(fix_used), .fixed_row(fixed_row), .protocol_error(protocol_error));
   lcs_host_model u_host (.clk(clk), .cs(cs), .ca(ca));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (n_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // bounded wait for a completion pulse
   task automatic wait_done(input logic rd);
      for (int i = 0; i < 30; i++) begin
         @(posedge clk);
         #1;
         if (rd ? mrr_valid === 1'h1 : cmd_valid === 1'h1) begin
            return;
         end
      end
      n_errors++;
      complete_run();
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      #1;
      chk("protocol_error", protocol_error, 0);
      chk("fix_used", fix_used, 0);
      u_host.mrr(FIX_RESOURCE_MODE_REGISTER);
      wait_done(1'h1);
      chk("mrr_data", mrr_data, RES);
      u_host.mrr(FIX_ENABLE_MODE_REGISTER);
      wait_done(1'h1);
      chk("mrr_data", mrr_data, MR_FIX_ENABLE_RESET);
      u_host.act(3'h3, 16'hA5C3);
      wait_done(1'h0);
      chk("bank_sel", bank_sel, 8'h08);
      chk("row", row, 16'hA5C3);
      for (int i = 0; i < 4; i++) begin
         u_host.one(t_cmd[i], {3'h0, t_ba[i]});
         wait_done(1'h0);
         chk("bank_sel", bank_sel, t_sel[i]);
      end
      // burst chosen per command
      @(posedge clk);
      otf_enable <= 1'h1;
      u_host.rw(5'h04, 3'h1, 1'h1, 1'h1, 10'h3F0);
      wait_done(1'h0);
      chk("auto_pre", auto_pre, 1);
      chk("burst32", burst32, 1);
      chk("col", col, 10'h3F0);
      u_host.rw(5'h02, 3'h0, 1'h0, 1'h0, 10'h2AC);
      wait_done(1'h0);
      chk("auto_pre", auto_pre, 0);
      chk("burst32", burst32, 0);
      chk("col", col, 10'h2AC);
      // fixed long burst; masked write stays short regardless
      @(posedge clk);
      otf_enable <= 1'h0;
      fixed_bl32 <= 1'h1;
      u_host.rw(5'h02, 3'h7, 1'h0, 1'h0, 10'h004);
      wait_done(1'h0);
      chk("burst32", burst32, 1);
      u_host.rw(5'h0C, 3'h4, 1'h0, 1'h1, 10'h1F0);
      wait_done(1'h0);
      chk("burst32", burst32, 0);
      chk("auto_pre", auto_pre, 1);
      // oscillator start needs no second half
      u_host.one(6'h00, 6'h07);
      wait_done(1'h0);
      chk("cmd_kind", cmd_kind, K_MPC);
      chk("protocol_error", protocol_error, 0);
      // two rows fused one after another
      u_host.repair(3'h2, 16'h1234);
      #1;
      chk("fix_used", fix_used, 8'h04);
      chk("fixed_row", fixed_row, 16'h1234);
      chk("fix_mode", fix_mode, 0);
      chk("fix_busy", fix_busy, 0);
      u_host.repair(3'h5, 16'hBEEF);
      #1;
      chk("fix_used", fix_used, 8'h24);
      chk("fixed_row", fixed_row, 16'hBEEF);
      // reopen the repaired row, as a host would before checking it
      u_host.act(3'h5, 16'hBEEF);
      wait_done(1'h0);
      chk("bank_sel", bank_sel, 8'h20);
      chk("row", row, 16'hBEEF);
      chk("protocol_error", protocol_error, 0);
      // activate first half broken off by a write
      u_host.issue(6'h01, 6'h00, 6'h04, 6'h00, 1'h1);
      repeat (8) @(posedge clk);
      chk("protocol_error", protocol_error, 1);
      // only a reset clears the error; then an oscillator command crowded by a precharge
      nrst <= 1'h0;
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      #1;
      chk("protocol_error", protocol_error, 0);
      u_host.issue(6'h00, 6'h07, 6'h10, 6'h00, 1'h1);
      repeat (8) @(posedge clk);
      chk("protocol_error", protocol_error, 1);
      complete_run();
   end
endmodule // tb_lcs_sequencer
